// file: srcc_defines.svh
/*
 * Constants of the system RAM controller: widths, AHB codes,
 * array depth. Assumes inclusion by bare name.
 */
`ifndef SRCC_DEFINES_SVH
`define SRCC_DEFINES_SVH

`define SRCC_AW 32
`define SRCC_DW 64
`define SRCC_EW 8
`define SRCC_IDXW 4
`define SRCC_DEPTH 16
`define SRCC_ADR_LO 3
`define SRCC_TAGW 29
`define SRCC_HTRANS_NSEQ 2'h2
`define SRCC_HSIZE_DW 3'h3
`define SRCC_RESP_OKAY 1'h0
`define SRCC_ECC_POISON 8'h03
`define SRCC_BUF_RST 1'h0
`define SRCC_WS_RST 1'h0

`endif

// file: srcc_pkg.sv
/*
 * Types of the system RAM controller. Assumes srcc_defines.svh.
 */
`include "srcc_defines.svh"

package srcc_pkg;
    typedef logic [`SRCC_DW-1:0] srcc_data_t;
    typedef logic [`SRCC_EW-1:0] srcc_ecc_t;
    typedef logic [`SRCC_IDXW-1:0] srcc_idx_t;
    typedef logic [`SRCC_TAGW-1:0] srcc_tag_t;
    typedef enum logic [2:0] {
        SRCC_IDLE = 3'h0,
        SRCC_WR = 3'h1,
        SRCC_RMW = 3'h3,
        SRCC_UE = 3'h2,
        SRCC_RD = 3'h4
    } srcc_state_e;
endpackage

// file: srcc_arr_if.sv
/*
 * Carrier between the controller and its array/store buffer.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none

interface srcc_arr_if;
    import srcc_pkg::*;
    logic wr_en;
    srcc_idx_t wr_idx;
    srcc_data_t wr_data;
    srcc_ecc_t wr_ecc;
    srcc_idx_t fd_idx;
    srcc_data_t fd_data;
    srcc_ecc_t fd_ecc;
    srcc_idx_t bd_idx;
    srcc_data_t bd_data;
    srcc_ecc_t bd_ecc;
    modport ctl(output wr_en, wr_idx, wr_data, wr_ecc, fd_idx, bd_idx,
        input fd_data, fd_ecc, bd_data, bd_ecc);
    modport arr(input wr_en, wr_idx, wr_data, wr_ecc, fd_idx, bd_idx,
        output fd_data, fd_ecc, bd_data, bd_ecc);
endinterface

`default_nettype wire

// file: srcc_store.sv
/*
 * Array of 64-bit words with 8-bit codes, plus a one-entry late-write
 * store buffer with read forwarding. Assumes sys_clk, sync rst.
 */
`timescale 1ns/10ps
`default_nettype none
`include "srcc_defines.svh"

module srcc_store
    import srcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    srcc_arr_if.arr arr
);
    srcc_data_t mem_data [`SRCC_DEPTH];
    srcc_ecc_t mem_ecc [`SRCC_DEPTH];
    logic buf_valid_reg;
    srcc_idx_t buf_idx_reg;
    srcc_data_t buf_data_reg;
    srcc_ecc_t buf_ecc_reg;

    // posted write lands here, array takes it one edge later
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            buf_valid_reg <= `SRCC_BUF_RST;
        end else begin
            buf_valid_reg <= arr.wr_en;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (arr.wr_en) begin
            buf_idx_reg <= arr.wr_idx;
            buf_data_reg <= arr.wr_data;
            buf_ecc_reg <= arr.wr_ecc;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (buf_valid_reg) begin
            mem_data[buf_idx_reg] <= buf_data_reg;
            mem_ecc[buf_idx_reg] <= buf_ecc_reg;
        end
    end

    // newest copy wins: incoming write, then buffer, then array
    always_comb begin
        if (arr.wr_en && arr.wr_idx == arr.fd_idx) begin
            arr.fd_data = arr.wr_data;
            arr.fd_ecc = arr.wr_ecc;
        end else if (buf_valid_reg && buf_idx_reg == arr.fd_idx) begin
            arr.fd_data = buf_data_reg;
            arr.fd_ecc = buf_ecc_reg;
        end else begin
            arr.fd_data = mem_data[arr.fd_idx];
            arr.fd_ecc = mem_ecc[arr.fd_idx];
        end
    end

    // no write forwarding: writes never share a cycle with a backdoor
    // read, and the merge read must see the old word
    always_comb begin
        if (buf_valid_reg && buf_idx_reg == arr.bd_idx) begin
            arr.bd_data = buf_data_reg;
            arr.bd_ecc = buf_ecc_reg;
        end else begin
            arr.bd_data = mem_data[arr.bd_idx];
            arr.bd_ecc = mem_ecc[arr.bd_idx];
        end
    end
endmodule

`default_nettype wire

// file: srcc_ctrl.sv
/*
 * System RAM controller: frontdoor AHB-Lite slave, backdoor overlay
 * read port, wait-state control, ECC read-modify-write.
 * Assumes single-slave AHB-Lite masters that send their own 8-bit
 * code with write data and check it on reads.
 */
`timescale 1ns/10ps
`default_nettype none
`include "srcc_defines.svh"

module srcc_ctrl
    import srcc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ws_sel,
    input wire logic fd_hsel,
    input wire logic [`SRCC_AW-1:0] fd_haddr,
    input wire logic [1:0] fd_htrans,
    input wire logic fd_hwrite,
    input wire logic [2:0] fd_hsize,
    input wire logic [2:0] fd_hburst,
    input wire logic fd_hready,
    input wire logic [`SRCC_DW-1:0] fd_hwdata,
    input wire logic [`SRCC_EW-1:0] fd_hwecc,
    output logic [`SRCC_DW-1:0] fd_hrdata,
    output logic [`SRCC_EW-1:0] fd_hrecc,
    output logic fd_hreadyout,
    output logic fd_hresp,
    input wire logic bd_hsel,
    input wire logic [`SRCC_AW-1:0] bd_haddr,
    input wire logic [1:0] bd_htrans,
    input wire logic bd_hready,
    output logic [`SRCC_DW-1:0] bd_hrdata,
    output logic [`SRCC_EW-1:0] bd_hrecc,
    output logic bd_hreadyout,
    output logic bd_hresp
);
    srcc_arr_if arr_if ();

    srcc_store u_store (
        .sys_clk(sys_clk),
        .rst(rst),
        .arr(arr_if)
    );

    srcc_state_e state_reg;
    logic ws_cnt_reg;
    logic [`SRCC_AW-1:0] pend_addr_reg;
    logic [2:0] pend_size_reg;
    logic [`SRCC_DW-1:0] fd_rdata_reg;
    logic [`SRCC_EW-1:0] fd_recc_reg;
    logic [`SRCC_DW-1:0] bd_rdata_reg;
    logic [`SRCC_EW-1:0] bd_recc_reg;
    logic bd_req;
    logic fd_acc;
    logic [`SRCC_DW-1:0] merged;
    logic [`SRCC_DW-1:0] lane_mask;
    logic [`SRCC_EW-1:0] syndrome;
    logic merge_ue;

    // parity masks by data bit index, address folded in; top bit overall
    function automatic srcc_ecc_t ecc_gen(input srcc_data_t d,
        input srcc_tag_t tag);
        srcc_ecc_t e;
        e = '0;
        for (int i = 0; i < 6; i++) begin
            for (int j = 0; j < `SRCC_DW; j++) begin
                if (j[i]) begin
                    e[i] = e[i] ^ d[j];
                end
            end
        end
        e[6] = ^tag;
        e[7] = (^d) ^ (^e[6:0]);
        return e;
    endfunction

    function automatic srcc_data_t byte_lanes(input logic [2:0] size,
        input logic [2:0] ofs);
        logic [7:0] b;
        srcc_data_t m;
        b = 8'h00;
        m = '0;
        case (size)
            3'h0: b = 8'h01 << ofs;
            3'h1: b = 8'h03 << {ofs[2:1], 1'h0};
            3'h2: b = 8'h0F << {ofs[2], 2'h0};
            default: b = 8'hFF;
        endcase
        for (int k = 0; k < 8; k++) begin
            m[k*8 +: 8] = {8{b[k]}};
        end
        return m;
    endfunction

    assign bd_req = bd_hsel && bd_htrans[1] && bd_hready;
    assign fd_acc = fd_hsel && fd_htrans[1] && fd_hready;

    // backdoor never waits; frontdoor yields whenever it asks
    assign bd_hreadyout = 1'h1;
    assign bd_hresp = `SRCC_RESP_OKAY;
    assign fd_hresp = `SRCC_RESP_OKAY;

    always_comb begin
        if (bd_req) begin
            fd_hreadyout = 1'h0;
        end else begin
            case (state_reg)
                SRCC_RD: fd_hreadyout = !ws_cnt_reg;
                SRCC_WR: fd_hreadyout =
                    (pend_size_reg == `SRCC_HSIZE_DW);
                SRCC_RMW: fd_hreadyout = !merge_ue;
                default: fd_hreadyout = 1'h1;
            endcase
        end
    end

    // hwdata is held by the master through the stall cycles
    assign lane_mask = byte_lanes(pend_size_reg, pend_addr_reg[2:0]);
    // merge reads the idle backdoor port: the frontdoor port forwards
    // the word being formed, which would loop back into the merge
    assign merged = (fd_hwdata & lane_mask) |
        (arr_if.bd_data & ~lane_mask);
    assign syndrome = arr_if.bd_ecc ^
        ecc_gen(arr_if.bd_data, pend_addr_reg[`SRCC_AW-1:`SRCC_ADR_LO]);
    assign merge_ue = (syndrome != '0) && !syndrome[7];

    assign arr_if.fd_idx = fd_acc ?
        fd_haddr[`SRCC_ADR_LO +: `SRCC_IDXW] :
        pend_addr_reg[`SRCC_ADR_LO +: `SRCC_IDXW];
    assign arr_if.bd_idx = bd_req ?
        bd_haddr[`SRCC_ADR_LO +: `SRCC_IDXW] :
        pend_addr_reg[`SRCC_ADR_LO +: `SRCC_IDXW];
    assign arr_if.wr_idx = pend_addr_reg[`SRCC_ADR_LO +: `SRCC_IDXW];

    always_comb begin
        arr_if.wr_en = 1'h0;
        arr_if.wr_data = merged;
        arr_if.wr_ecc = ecc_gen(merged,
            pend_addr_reg[`SRCC_AW-1:`SRCC_ADR_LO]);
        if (!bd_req) begin
            case (state_reg)
                SRCC_WR: begin
                    if (pend_size_reg == `SRCC_HSIZE_DW) begin
                        arr_if.wr_en = 1'h1;
                        arr_if.wr_data = fd_hwdata;
                        arr_if.wr_ecc = fd_hwecc;
                    end
                end
                SRCC_RMW: arr_if.wr_en = !merge_ue;
                SRCC_UE: begin
                    // keep the word flagged bad rather than hide the fault
                    arr_if.wr_en = 1'h1;
                    arr_if.wr_ecc = ecc_gen(merged,
                        pend_addr_reg[`SRCC_AW-1:`SRCC_ADR_LO]) ^
                        `SRCC_ECC_POISON;
                end
                default: arr_if.wr_en = 1'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= SRCC_IDLE;
            ws_cnt_reg <= `SRCC_WS_RST;
        end else if (fd_acc) begin
            state_reg <= fd_hwrite ? SRCC_WR : SRCC_RD;
            // only the first beat of a burst pays the wait state
            ws_cnt_reg <= !fd_hwrite && ws_sel &&
                fd_htrans == `SRCC_HTRANS_NSEQ;
        end else if (!bd_req) begin
            case (state_reg)
                SRCC_RD: begin
                    ws_cnt_reg <= 1'h0;
                    if (!ws_cnt_reg) begin
                        state_reg <= SRCC_IDLE;
                    end
                end
                SRCC_WR: begin
                    state_reg <= (pend_size_reg == `SRCC_HSIZE_DW) ?
                        SRCC_IDLE : SRCC_RMW;
                end
                SRCC_RMW: state_reg <= merge_ue ? SRCC_UE : SRCC_IDLE;
                default: state_reg <= SRCC_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pend_addr_reg <= '0;
            pend_size_reg <= 3'h0;
        end else if (fd_acc) begin
            pend_addr_reg <= fd_haddr;
            pend_size_reg <= fd_hsize;
        end
    end

    // reload while stalled so a preempted read sees the newest copy
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fd_rdata_reg <= '0;
            fd_recc_reg <= '0;
        end else if ((fd_acc && !fd_hwrite) || state_reg == SRCC_RD) begin
            fd_rdata_reg <= arr_if.fd_data;
            fd_recc_reg <= arr_if.fd_ecc;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bd_rdata_reg <= '0;
            bd_recc_reg <= '0;
        end else if (bd_req) begin
            bd_rdata_reg <= arr_if.bd_data;
            bd_recc_reg <= arr_if.bd_ecc;
        end
    end

    assign fd_hrdata = fd_rdata_reg;
    assign fd_hrecc = fd_recc_reg;
    assign bd_hrdata = bd_rdata_reg;
    assign bd_hrecc = bd_recc_reg;
endmodule

`default_nettype wire

// file: srcc_ctrl_monitor.sv
/* port checker for srcc_ctrl; assumes fd_hready and bd_hready are
   looped back from the readyout outputs by the system */
`timescale 1ns/10ps
`default_nettype none
`include "srcc_defines.svh"
module srcc_ctrl_mon(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ws_sel,
    input wire logic fd_hsel,
    input wire logic [1:0] fd_htrans,
    input wire logic fd_hwrite,
    input wire logic [2:0] fd_hsize,
    input wire logic fd_hready,
    input wire logic [`SRCC_DW-1:0] fd_hrdata,
    input wire logic fd_hreadyout,
    input wire logic fd_hresp,
    input wire logic bd_hsel,
    input wire logic [1:0] bd_htrans,
    input wire logic bd_hready,
    input wire logic bd_hreadyout,
    input wire logic bd_hresp
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic tk = fd_hsel && fd_htrans[1] && fd_hready;
    wire logic bq = bd_hsel && bd_htrans[1] && bd_hready;
    logic rd_ph_reg;
    // read data phase open until hreadyout closes it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_ph_reg <= 1'b0;
        end else if (tk) begin
            rd_ph_reg <= !fd_hwrite;
        end else if (fd_hreadyout) begin
            rd_ph_reg <= 1'b0;
        end
    end
    wire logic rd_ld = rd_ph_reg || (tk && !fd_hwrite);
    sequence s_dw; tk && fd_hwrite && fd_hsize == 3'h3; endsequence
    sequence s_nw; tk && fd_hwrite && fd_hsize != 3'h3; endsequence
    sequence s_rf;
        tk && !fd_hwrite && (!ws_sel || fd_htrans == 2'h3);
    endsequence
    sequence s_rs;
        tk && !fd_hwrite && ws_sel && fd_htrans == 2'h2;
    endsequence
    property p_okay; !fd_hresp && !bd_hresp; endproperty
    property p_bd_rdy; bd_hreadyout; endproperty
    property p_bd_win; bq |-> !fd_hreadyout; endproperty
    property p_dw; s_dw ##1 !bq |-> fd_hreadyout; endproperty
    property p_rf; s_rf ##1 !bq |-> fd_hreadyout; endproperty
    property p_rs1; s_rs ##1 !bq |-> !fd_hreadyout; endproperty
    property p_rs2; s_rs ##1 !bq [*2] |-> fd_hreadyout; endproperty
    property p_rmw; s_nw ##1 !bq |-> !fd_hreadyout; endproperty
    property p_rmw_max;
        s_nw ##1 !bq [*3] |-> fd_hreadyout || $past(fd_hreadyout);
    endproperty
    property p_hold; !$stable(fd_hrdata) |-> $past(rd_ld); endproperty
    a_okay: assert property (p_okay) else $error("bad hresp");
    a_bd_rdy: assert property (p_bd_rdy) else $error("bd stall");
    a_bd_win: assert property (p_bd_win) else $error("fd won");
    a_dw: assert property (p_dw) else $error("dw write wait");
    a_rf: assert property (p_rf) else $error("fast read late");
    a_rs1: assert property (p_rs1) else $error("slow read early");
    a_rs2: assert property (p_rs2) else $error("slow read late");
    a_rmw: assert property (p_rmw) else $error("no rmw stall");
    a_rmw_max: assert property (p_rmw_max) else $error("rmw long");
    a_hold: assert property (p_hold) else $error("rdata moved");
endmodule
bind srcc_ctrl srcc_ctrl_mon u_mon(.sys_clk, .rst, .ws_sel, .fd_hsel,
    .fd_htrans, .fd_hwrite, .fd_hsize, .fd_hready, .fd_hrdata,
    .fd_hreadyout, .fd_hresp, .bd_hsel, .bd_htrans, .bd_hready,
    .bd_hreadyout, .bd_hresp);
`default_nettype wire

// file: srcc_bd_model.sv
/* overlay read master on the backdoor port; one read per rising
   edge of go; assumes the shared sys_clk */
`timescale 1ns/10ps
`default_nettype none
module srcc_bd_model(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [31:0] addr,
    input wire logic bd_hreadyout,
    input wire logic [63:0] bd_hrdata,
    output logic bd_hsel,
    output logic [31:0] bd_haddr,
    output logic [1:0] bd_htrans,
    output logic [63:0] got
);
    logic go_q;
    logic pend;
    always_ff @(posedge sys_clk) begin
        go_q <= go;
        pend <= !rst && bd_htrans[1] && bd_hreadyout;
        if (pend) begin
            got <= bd_hrdata;
        end
        if (rst) begin
            bd_hsel <= 1'b0;
            bd_htrans <= 2'h0;
            bd_haddr <= 32'h0;
        end else if (bd_htrans[1] && bd_hreadyout) begin
            bd_hsel <= 1'b0;
            bd_htrans <= 2'h0;
            // idle address toggles, never a stale copy
            bd_haddr <= ~bd_haddr;
        end else if (go && !go_q) begin
            bd_hsel <= 1'b1;
            bd_htrans <= 2'h2;
            bd_haddr <= addr;
        end
    end
endmodule
`default_nettype wire

// file: srcc_tb.sv
/* self-checking bench for srcc_ctrl; assumes srcc_bd_model as
   backdoor master and fd_hready looped from fd_hreadyout */
`timescale 1ns/10ps
`default_nettype none
`include "srcc_defines.svh"
module testbench;
    import srcc_pkg::*;
    logic sys_clk = 0, rst = 1, ws_sel = 0, fd_hsel = 1;
    logic fd_hwrite = 0, bd_go = 0, fd_hreadyout, fd_hresp;
    logic bd_hsel, bd_hreadyout, bd_hresp;
    logic [31:0] fd_haddr = 0, bd_addr = 0, bd_haddr;
    logic [1:0] fd_htrans = 0, bd_htrans;
    logic [2:0] fd_hsize = 0, fd_hburst = 0;
    srcc_data_t fd_hwdata = 0, fd_hrdata, bd_hrdata, bd_got, rd;
    srcc_ecc_t fd_hwecc = 0, fd_hrecc, bd_hrecc, rc;
    int n_errors = 0, comparisons = 0;
    srcc_ctrl DUT(.sys_clk, .rst, .ws_sel, .fd_hsel, .fd_haddr,
        .fd_htrans, .fd_hwrite, .fd_hsize, .fd_hburst,
        .fd_hready(fd_hreadyout), .fd_hwdata, .fd_hwecc, .fd_hrdata,
        .fd_hrecc, .fd_hreadyout, .fd_hresp, .bd_hsel, .bd_haddr,
        .bd_htrans, .bd_hready(bd_hreadyout), .bd_hrdata, .bd_hrecc,
        .bd_hreadyout, .bd_hresp);
    srcc_bd_model u_bd(.sys_clk, .rst, .go(bd_go), .addr(bd_addr),
        .bd_hreadyout, .bd_hrdata, .bd_hsel, .bd_haddr, .bd_htrans,
        .got(bd_got));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task tally_and_finish;
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task check(input string nm, input logic [63:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask
    // bounded; returns on the edge that samples ready high
    task wait_rdy(output int n);
        n = 0;
        @(negedge sys_clk);
        while (fd_hreadyout !== 1'b1) begin
            n++;
            if (n > 40) begin
                check("ready wait", 1, 0);
                tally_and_finish();
            end
            @(negedge sys_clk);
        end
        rd = fd_hrdata;
        rc = fd_hrecc;
        @(posedge sys_clk);
    endtask
    // single transfer, not pipelined: keeps wait counts exact
    task ahb(input logic w, input logic [2:0] sz, input logic [31:0] a,
        input srcc_data_t wd, input srcc_ecc_t we, output int ws);
        int n;
        fd_htrans <= 2'h2;
        fd_haddr <= a;
        fd_hwrite <= w;
        fd_hsize <= sz;
        wait_rdy(n);
        fd_htrans <= 2'h0;
        fd_hwdata <= wd;
        fd_hwecc <= we;
        wait_rdy(ws);
    endtask
    task t_dword;
        int ws;
        srcc_data_t m;
        ahb(1, 3'h3, 32'h10, 64'h0123456789ABCDEF, 8'h5A, ws);
        check("dw write ws", ws, 0);
        for (int i = 0; i < 4; i++) begin
            m = (i == 3) ? '1 : (64'h1 << (8 << i)) - 64'h1;
            ws_sel <= i[0];
            ahb(0, i[2:0], 32'h10, 0, 0, ws);
            check("read ws", ws, i % 2);
            check("read data", rd & m, 64'h0123456789ABCDEF & m);
            check("read code", rc, 8'h5A);
        end
    endtask
    task t_narrow;
        int ws;
        srcc_data_t v[3] = '{64'hAB, 64'h1234, 64'hDEADBEEF};
        ahb(1, 3'h3, 32'h0, 0, 8'h00, ws);
        for (int i = 0; i < 3; i++) begin
            ahb(1, i[2:0], 32'h1 << i, v[i] << (8 << i), 0, ws);
            check("narrow write ws", ws, 1);
        end
        ahb(0, 3'h3, 32'h0, 0, 0, ws);
        check("merged word", rd, 64'hDEADBEEF1234AB00);
    endtask
    task t_ue;
        int ws;
        // zero word at tag 0 has code 0, so 0x03 is a double error
        ahb(1, 3'h3, 32'h0, 0, 8'h03, ws);
        ahb(1, 3'h0, 32'h3, 64'h55 << 24, 0, ws);
        check("ue merge ws", ws, 2);
        // same word and code at tag 1: syndrome top bit set, no extra wait
        ahb(1, 3'h3, 32'h8, 0, 8'h03, ws);
        ahb(1, 3'h0, 32'h8, 64'h55, 0, ws);
        check("tagged merge ws", ws, 1);
    endtask
    task t_burst(input logic ws, input logic bd);
        int w, tot;
        for (int k = 0; k < 4; k++) begin
            ahb(1, 3'h3, 32'h20 + 8 * k, 64'hC0DE0000 + k, 0, w);
        end
        ws_sel <= ws;
        bd_addr <= 32'h10;
        fd_hwrite <= 1'b0;
        fd_hburst <= 3'h3;
        fd_htrans <= 2'h2;
        fd_haddr <= 32'h20;
        wait_rdy(w);
        tot = 0;
        for (int k = 0; k < 4; k++) begin
            fd_htrans <= (k < 3) ? 2'h3 : 2'h0;
            fd_haddr <= 32'h28 + 8 * k;
            bd_go <= bd && k == 1;
            wait_rdy(w);
            tot += w;
            check("beat data", rd, 64'hC0DE0000 + k);
            if (!bd) check("beat ws", w, k == 0 ? ws : 0);
        end
        if (bd) check("preempted ws", tot, ws + 1);
        if (bd) check("overlay data", bd_got, 64'h0123456789ABCDEF);
        if (bd) check("overlay code", bd_hrecc, 8'h5A);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_dword();
        t_narrow();
        t_ue();
        t_burst(1, 0);
        t_burst(0, 1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
